// ### inc/src_pkg.sv
// Package of constants, types and helpers for the system reset controller
package src_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_BROWNOUT_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIPH_RST0 = 8'h04;
  localparam logic [7:0] OFS_PERIPH_RST1 = 8'h08;
  localparam logic [7:0] OFS_PERIPH_RST2 = 8'h0C;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h10;

  // Brown-out control fields
  localparam int unsigned BROWNOUT_SEL_BIT = 1;
  localparam logic [31:0] BROWNOUT_CTRL_MASK = 32'h0000_0002;
  localparam logic [31:0] BROWNOUT_CTRL_RESET = 32'h0000_0000;

  // Reset cause bit positions and power-on value
  localparam int unsigned CAUSE_POR = 0;
  localparam int unsigned CAUSE_EXT = 1;
  localparam int unsigned CAUSE_BROWNOUT = 2;
  localparam int unsigned CAUSE_WDT = 3;
  localparam int unsigned CAUSE_SW = 4;
  localparam logic [31:0] CAUSE_POR_VALUE = 32'h0000_0001;
  localparam logic [31:0] CAUSE_MASK = 32'h0000_001F;

  // Peripheral reset register bank
  localparam int unsigned PERIPH_REGS = 3;
  localparam int unsigned PERIPH_W = 32;
  localparam logic [31:0] PERIPH_RST_RESET = 32'h0000_0000;

  // Last hold count of the internal reset stretch after the last source clears; the stretch lasts eight cycles
  localparam logic [3:0] HOLD_LAST = 4'h7;

  // Boot fetch selector codes towards the core
  localparam logic [1:0] FETCH_SEL_SP = 2'h0;
  localparam logic [1:0] FETCH_SEL_PC = 2'h1;
  localparam logic [1:0] FETCH_SEL_INSN = 2'h2;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_FETCH_SP,
    ST_FETCH_PC,
    ST_FETCH_INSN,
    ST_RUN
  } src_state_t;

  // Byte enables widened to a bit mask
  function automatic logic [31:0] src_be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : src_be_mask

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] src_merge(input logic [31:0] old_v,
                                            input logic [31:0] wr_v,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = src_be_mask(be);
    return (old_v & ~m) | (wr_v & m);
  endfunction : src_merge

endpackage : src_pkg

// ### hdl/src_top.sv
// System reset controller: sources, domains, cause register, boot release

// What this block does
// - Five sources: pin, power-on, brown-out, software, watchdog
// - Power-on resets core, debug TAP, peripherals
// - Pin resets core, peripherals, TAP pin config only
// - Brown-out resets core and peripherals like pin, but not TAP pin config; held while present
// - Brown-out reset off until software enables it
// - Brown-out: reset if select set, else interrupt
// - Software request resets core and peripherals, not TAP
// - Peripheral reset by setting then clearing its bit
// - Three peripheral reset registers, clock-gate bit layout
// - Peripheral reset drives all its clock domains
// - Watchdog resets core and peripherals, not TAP
// - Cause register bit set for each source
// - Cause bits sticky across non power-on resets
// - Power-on clears causes, sets power-on bit
// - Release fetches stack pointer, PC, instruction, runs
// - Internal reset held while power-on detector active
// - Power-on detector acts only at power-up
// - Software reset asserts, deasserts, then boot fetch
// - Power-on loads identification instruction; pin does not
module src_top
  import src_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic ext_reset_n_i,
  input wire logic bod_detect_i,
  input wire logic sys_reset_req_i,
  input wire logic wdog_reset_i,
  input wire logic fetch_ack_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic core_reset_n_o,
  output logic tap_reset_n_o,
  output logic tap_pin_cfg_reset_n_o,
  output logic tap_load_id_o,
  output logic [95:0] periph_run_rst_n_o,
  output logic [95:0] periph_slp_rst_n_o,
  output logic fetch_req_o,
  output logic [1:0] fetch_sel_o,
  output logic core_run_o,
  output logic brownout_int_o
);

  logic ext_clr_n;
  logic [2:0] ext_ff_reg;
  logic ext_ok;
  logic ext_fill_reg;
  logic [2:0] bod_ff_reg;
  logic bod_level_reg;
  logic bod_rst;
  logic sys_src;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic wr_fire;
  logic reset_cause_register_wr;
  logic [31:0] bctrl_reg;
  logic [31:0] periph_reg [PERIPH_REGS];
  logic [95:0] periph_flat;
  logic [95:0] periph_rst_n_reg;
  logic [31:0] cause_reg;
  logic [31:0] cause_next;
  logic [31:0] cause_evt;
  src_state_t state_reg;
  src_state_t state_next;
  logic [3:0] hold_cnt_reg;
  logic [3:0] hold_next;
  logic core_rst_n_reg;
  logic tap_rst_n_reg;
  logic tap_pin_n_reg;
  logic tap_id_reg;
  logic bod_int_reg;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  // Pin synchroniser; power-on also clears it so it starts asserted
  assign ext_clr_n = ext_reset_n_i & reset_n_i;

  // Async assertion by the pin, release after three clean edges
  always_ff @(posedge clk_sys_i or negedge ext_clr_n) begin
    if (!ext_clr_n) begin
      ext_ff_reg <= 3'h0;
    end else begin
      ext_ff_reg <= {ext_ff_reg[1:0], 1'b1};
    end
  end

  // Released only once second and third stage are both high
  assign ext_ok = ext_ff_reg[1] & ext_ff_reg[2];

  // Brown-out detector is asynchronous: three stages and agreement
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bod_ff_reg <= 3'h0;
      bod_level_reg <= 1'b0;
    end else begin
      bod_ff_reg <= {bod_ff_reg[1:0], bod_detect_i};
      if (bod_ff_reg[1] == bod_ff_reg[2]) begin
        bod_level_reg <= bod_ff_reg[2];
      end
    end
  end

  // Select bit decides reset versus interrupt; clear after power-on
  assign bod_rst = bod_level_reg & bctrl_reg[BROWNOUT_SEL_BIT];

  // Any source that reaches the core; power-on enters by async reset
  assign sys_src = ~ext_ok | bod_rst | sys_reset_req_i | wdog_reset_i;

  // Avalon-MM: one wait cycle, then answer on the second edge
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign wr_fire = avs_write_i & ack_reg;
  assign reset_cause_register_wr = wr_fire & (avs_address_i == OFS_RESET_CAUSE);
  assign avs_readdata_o = rdata_reg;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    unique case (avs_address_i)
      OFS_BROWNOUT_CTRL: rd_mux = bctrl_reg;
      OFS_PERIPH_RST0: rd_mux = periph_reg[0];
      OFS_PERIPH_RST1: rd_mux = periph_reg[1];
      OFS_PERIPH_RST2: rd_mux = periph_reg[2];
      OFS_RESET_CAUSE: rd_mux = cause_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle so it stands at the answer
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_i && !ack_reg) begin
      rdata_reg <= rd_mux;
    end
  end

  // Brown-out control survives every reset except power-on
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bctrl_reg <= BROWNOUT_CTRL_RESET;
    end else if (wr_fire && avs_address_i == OFS_BROWNOUT_CTRL) begin
      bctrl_reg <= src_merge(bctrl_reg, avs_writedata_i,
                             avs_byteenable_i) & BROWNOUT_CTRL_MASK;
    end
  end

  // Peripheral reset bank; a system reset clears it with the peripherals
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < PERIPH_REGS; i++) begin
        periph_reg[i] <= PERIPH_RST_RESET;
      end
    end else if (!core_rst_n_reg) begin
      for (int i = 0; i < PERIPH_REGS; i++) begin
        periph_reg[i] <= PERIPH_RST_RESET;
      end
    end else if (wr_fire) begin
      for (int i = 0; i < PERIPH_REGS; i++) begin
        if (avs_address_i == OFS_PERIPH_RST0 + 8'(i * 4)) begin
          periph_reg[i] <= src_merge(periph_reg[i], avs_writedata_i,
                                     avs_byteenable_i);
        end
      end
    end
  end

  assign periph_flat = {periph_reg[2], periph_reg[1], periph_reg[0]};

  // Peripheral held while its bit is set or the system is in reset;
  // the unit leaves reset when software clears the bit again
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      periph_rst_n_reg <= '0;
    end else begin
      periph_rst_n_reg <= ~(periph_flat |
                            {96{state_next == ST_HOLD}});
    end
  end

  // Both clock domains of a unit share one reset image
  assign periph_run_rst_n_o = periph_rst_n_reg;
  assign periph_slp_rst_n_o = periph_rst_n_reg;

  // Events that mark their cause bit this cycle
  always_comb begin
    cause_evt = 32'h0000_0000;
    cause_evt[CAUSE_EXT] = ~ext_ok & ~ext_fill_reg;
    cause_evt[CAUSE_BROWNOUT] = bod_rst;
    cause_evt[CAUSE_WDT] = wdog_reset_i;
    cause_evt[CAUSE_SW] = sys_reset_req_i;
  end

  // Write-one-to-clear, but a same-cycle event wins over the clear
  always_comb begin
    cause_next = cause_reg;
    if (reset_cause_register_wr) begin
      cause_next = cause_next &
        ~(avs_writedata_i & src_be_mask(avs_byteenable_i));
    end
    cause_next = (cause_next | cause_evt) & CAUSE_MASK;
  end

  // Only power-on rewrites the whole register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cause_reg <= CAUSE_POR_VALUE;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // Reset sequencer: hold, stretch, then the three boot fetches
  always_comb begin
    state_next = state_reg;
    hold_next = hold_cnt_reg;
    if (sys_src) begin
      state_next = ST_HOLD;
      hold_next = 4'h0;
    end else begin
      unique case (state_reg)
        ST_HOLD: begin
          if (hold_cnt_reg == HOLD_LAST) begin
            state_next = ST_FETCH_SP;
          end else begin
            hold_next = hold_cnt_reg + 4'h1;
          end
        end
        ST_FETCH_SP: begin
          if (fetch_ack_i) begin
            state_next = ST_FETCH_PC;
          end
        end
        ST_FETCH_PC: begin
          if (fetch_ack_i) begin
            state_next = ST_FETCH_INSN;
          end
        end
        ST_FETCH_INSN: begin
          if (fetch_ack_i) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          state_next = ST_RUN;
        end
      endcase
    end
  end

  // Power-on holds the sequencer in reset until the detector lets go
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_HOLD;
      hold_cnt_reg <= 4'h0;
      core_rst_n_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_next;
      core_rst_n_reg <= (state_next != ST_HOLD);
    end
  end

  assign core_reset_n_o = core_rst_n_reg;
  assign fetch_req_o = (state_reg == ST_FETCH_SP) ||
                       (state_reg == ST_FETCH_PC) ||
                       (state_reg == ST_FETCH_INSN);
  assign core_run_o = (state_reg == ST_RUN);

  // Selector decode of the fetch step
  always_comb begin
    unique case (state_reg)
      ST_FETCH_PC: fetch_sel_o = FETCH_SEL_PC;
      ST_FETCH_INSN: fetch_sel_o = FETCH_SEL_INSN;
      default: fetch_sel_o = FETCH_SEL_SP;
    endcase
  end

  // TAP: full reset and ID load only at power-up; the detector input
  // never fires again, so later resets leave the TAP alone
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tap_rst_n_reg <= 1'b0;
      tap_id_reg <= 1'b1;
    end else begin
      tap_rst_n_reg <= 1'b1;
      tap_id_reg <= 1'b0;
    end
  end

  // Pin config follows the pin only; chain refill after power-on no cause
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tap_pin_n_reg <= 1'b0;
      ext_fill_reg <= 1'b1;
    end else begin
      tap_pin_n_reg <= ext_ok;
      ext_fill_reg <= ext_fill_reg & ~ext_ok;
    end
  end

  assign tap_reset_n_o = tap_rst_n_reg;
  assign tap_load_id_o = tap_id_reg;
  assign tap_pin_cfg_reset_n_o = tap_pin_n_reg;

  // Interrupt instead of reset when the select bit is clear
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bod_int_reg <= 1'b0;
    end else begin
      bod_int_reg <= bod_level_reg & ~bctrl_reg[BROWNOUT_SEL_BIT];
    end
  end

  assign brownout_int_o = bod_int_reg;

  // Checks on the sequencer, cause register and domains
  a_wdog_core_reset: assert property (
    wdog_reset_i |=> !core_reset_n_o ##1 !core_reset_n_o)
    else $error("watchdog did not hold the core in reset");

  a_wdog_cause_bit: assert property (
    wdog_reset_i |=> cause_reg[CAUSE_WDT])
    else $error("watchdog cause bit not set");

  a_tap_not_reset: assert property (
    tap_reset_n_o || $past(!reset_n_i))
    else $error("TAP reset outside power-on");

  a_bod_held_reset: assert property (
    bod_rst |=> !core_reset_n_o && !periph_run_rst_n_o[0])
    else $error("brown-out did not hold core and peripherals");

  a_bod_int_path: assert property (
    (bod_level_reg && !bctrl_reg[BROWNOUT_SEL_BIT]) |=>
      (brownout_int_o && !cause_reg[CAUSE_BROWNOUT]) ||
      $past(cause_reg[CAUSE_BROWNOUT]))
    else $error("brown-out interrupt path wrong");

  a_swreq_stretch: assert property (
    (sys_reset_req_i && core_run_o) |=> !core_reset_n_o [*8] ##[1:300]
      state_reg == ST_FETCH_SP || sys_src)
    else $error("software reset stretch or release wrong");

  a_cause_sticky_bits: assert property (
    $past(!reset_cause_register_wr) |-> ((cause_reg & $past(cause_reg)) == $past(cause_reg)))
    else $error("cause bit lost without a clear");

  a_cause_w1c_clear: assert property (
    (reset_cause_register_wr && avs_writedata_i[CAUSE_WDT] && avs_byteenable_i[0] &&
     !wdog_reset_i) |=> !cause_reg[CAUSE_WDT])
    else $error("cause bit not cleared by write");

  a_periph_bit_hold: assert property (
    periph_reg[1][3] |=> !periph_run_rst_n_o[35] && !periph_slp_rst_n_o[35])
    else $error("peripheral not held by its bit");

  a_fetch_sequence: assert property (
    (state_reg == ST_FETCH_SP && fetch_ack_i && !sys_src) |=>
      fetch_sel_o == FETCH_SEL_PC && fetch_req_o)
    else $error("boot fetch order broken");

  a_pin_reset_core: assert property (
    !ext_ok |=> !core_reset_n_o && !tap_pin_cfg_reset_n_o && tap_reset_n_o)
    else $error("pin reset domains wrong");

  // Main scenarios
  c_boot_done: cover property (
    state_reg == ST_FETCH_INSN && fetch_ack_i && !sys_src);
  c_sw_reset: cover property (sys_reset_req_i && core_run_o);
  c_bod_reset: cover property (bod_rst ##1 !bod_rst);
  c_periph_pulse: cover property (periph_reg[0][0] ##1 !periph_reg[0][0]);

endmodule : src_top

// ### sim/src_core_model.sv
// Core model: answers boot fetches and checks their order
module src_core_model
  import src_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic core_reset_n_i,
  input wire logic fetch_req_i,
  input wire logic [1:0] fetch_sel_i,
  input wire logic core_run_i,
  input wire logic slow_i,
  output logic fetch_ack_o,
  output logic order_err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_reg;
  logic [1:0] idx_reg;
  logic run_d_reg;

  // One ack pulse per fetch; slow mode waits three cycles first
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fetch_ack_o <= 1'b0;
      wait_reg <= 2'h0;
    end else if (fetch_req_i && core_reset_n_i && !fetch_ack_o) begin
      if (!slow_i || wait_reg == 2'h3) begin
        fetch_ack_o <= 1'b1;
        wait_reg <= 2'h0;
      end else begin
        wait_reg <= wait_reg + 2'h1;
      end
    end else begin
      fetch_ack_o <= 1'b0;
    end
  end

  // Sticky error if fetches skip a step or run starts early
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx_reg <= 2'h0;
      run_d_reg <= 1'b0;
      order_err_o <= 1'b0;
    end else begin
      run_d_reg <= core_run_i;
      if (!core_reset_n_i) begin
        idx_reg <= 2'h0;
      end else if (fetch_ack_o && fetch_req_i) begin
        if (fetch_sel_i != idx_reg) order_err_o <= 1'b1;
        idx_reg <= idx_reg + 2'h1;
      end
      if (core_run_i && !run_d_reg && idx_reg != 2'h3) begin
        order_err_o <= 1'b1;
      end
    end
  end
endmodule : src_core_model

// ### sim/src_top_tb_top.sv
// Bench for the system reset controller with a core model
module src_top_tb_top
  import src_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] b;
    logic [31:0] e;
  } src_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_n = 1'b1;
  logic bod = 1'b0;
  logic swreq = 1'b0;
  logic wdog = 1'b0;
  logic slow = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdata, q;
  logic waitreq, core_n, tap_n, pin_n, load_id, freq, run, bint, ack, err;
  logic [1:0] fsel;
  logic [95:0] prun_n, pslp_n;
  int fail_count = 0;
  int compares = 0;
  // Writes then reads back; unmapped and masked places read zero
  src_row_t rows [5] = '{
    '{OFS_BROWNOUT_CTRL, 32'hFFFF_FFFF, 4'hF, 32'h0000_0002},
    '{OFS_PERIPH_RST0, 32'hA5A5_0001, 4'hF, 32'hA5A5_0001},
    '{OFS_PERIPH_RST1, 32'h1234_5678, 4'h2, 32'h0000_5600},
    '{OFS_PERIPH_RST2, 32'h8000_0000, 4'hF, 32'h8000_0000},
    '{8'h20, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000}};

  always #20 clk = ~clk;

  src_top uut (.clk_sys_i(clk), .reset_n_i(rst_n), .ext_reset_n_i(ext_n),
    .bod_detect_i(bod), .sys_reset_req_i(swreq), .wdog_reset_i(wdog),
    .fetch_ack_i(ack), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wd),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .core_reset_n_o(core_n), .tap_reset_n_o(tap_n),
    .tap_pin_cfg_reset_n_o(pin_n), .tap_load_id_o(load_id),
    .periph_run_rst_n_o(prun_n), .periph_slp_rst_n_o(pslp_n),
    .fetch_req_o(freq), .fetch_sel_o(fsel), .core_run_o(run),
    .brownout_int_o(bint));

  src_core_model core_model (.clk_sys_i(clk), .reset_n_i(rst_n),
    .core_reset_n_i(core_n), .fetch_req_i(freq), .fetch_sel_i(fsel),
    .core_run_i(run), .slow_i(slow), .fetch_ack_o(ack),
    .order_err_o(err));

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // Avalon cycle; held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    be <= b;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) fail_count++;
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk32(q, e);
  endtask : rd_chk

  // Let edges land, then look in mid-cycle
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Bounded wait for the boot fetches to finish
  task automatic wait_boot;
    int n;
    n = 0;
    while (run !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk1(run, 1'b1);
    // The model flags an early run start one edge later
    @(negedge clk);
    chk1(err, 1'b0);
  endtask : wait_boot

  task automatic done(input string s);
    $display("TEST %s done", s);
  endtask : done

  task automatic tally_and_finish;
    $display("COUNTS compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #160000;
    fail_count++;
    tally_and_finish();
  end

  initial begin : main
    settle(1);
    chk1(core_n, 1'b0);
    chk1(tap_n, 1'b0);
    chk1(prun_n[95], 1'b0);
    chk1(load_id, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_boot();
    chk1(tap_n, 1'b1);
    rd_chk(OFS_RESET_CAUSE, CAUSE_POR_VALUE);
    rd_chk(OFS_BROWNOUT_CTRL, BROWNOUT_CTRL_RESET);
    done("power_on");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].b);
      rd_chk(rows[i].a, rows[i].e);
    end
    // Clear select and peripheral bits so later tests start from rest
    for (int i = 0; i < 4; i++) bus(1'b1, 8'(i * 4), 32'h0, 4'hF);
    done("registers");
    bus(1'b1, OFS_PERIPH_RST1, 32'h0000_0008, 4'hF);
    settle(2);
    chk1(prun_n[35], 1'b0);
    chk1(pslp_n[35], 1'b0);
    chk1(prun_n[34], 1'b1);
    chk1(core_n, 1'b1);
    chk1(tap_n, 1'b1);
    bus(1'b1, OFS_PERIPH_RST1, 32'h0000_0000, 4'hF);
    settle(2);
    chk1(prun_n[35], 1'b1);
    done("periph");
    @(posedge clk);
    ext_n <= 1'b0;
    settle(4);
    chk1(core_n, 1'b0);
    chk1(prun_n[0], 1'b0);
    chk1(tap_n, 1'b1);
    chk1(pin_n, 1'b0);
    chk1(load_id, 1'b0);
    @(posedge clk);
    ext_n <= 1'b1;
    wait_boot();
    rd_chk(OFS_RESET_CAUSE, 32'h0000_0003);
    bus(1'b1, OFS_RESET_CAUSE, 32'h0000_001F, 4'hF);
    rd_chk(OFS_RESET_CAUSE, 32'h0000_0000);
    done("pin");
    @(posedge clk);
    bod <= 1'b1;
    settle(8);
    chk1(bint, 1'b1);
    chk1(core_n, 1'b1);
    @(posedge clk);
    bod <= 1'b0;
    settle(8);
    chk1(bint, 1'b0);
    rd_chk(OFS_RESET_CAUSE, 32'h0000_0000);
    bus(1'b1, OFS_BROWNOUT_CTRL, 32'h0000_0002, 4'hF);
    @(posedge clk);
    bod <= 1'b1;
    settle(8);
    chk1(core_n, 1'b0);
    chk1(tap_n, 1'b1);
    settle(12);
    chk1(core_n, 1'b0);
    chk1(freq, 1'b0);
    @(posedge clk);
    bod <= 1'b0;
    wait_boot();
    rd_chk(OFS_RESET_CAUSE, 32'h0000_0004);
    rd_chk(OFS_BROWNOUT_CTRL, 32'h0000_0002);
    done("brownout");
    @(posedge clk);
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    settle(1);
    chk1(core_n, 1'b0);
    chk1(prun_n[64], 1'b0);
    chk1(tap_n, 1'b1);
    wait_boot();
    rd_chk(OFS_RESET_CAUSE, 32'h0000_000C);
    done("watchdog");
    @(posedge clk);
    slow <= 1'b1;
    swreq <= 1'b1;
    @(posedge clk);
    swreq <= 1'b0;
    settle(1);
    chk1(core_n, 1'b0);
    chk1(prun_n[31], 1'b0);
    chk1(tap_n, 1'b1);
    wait_boot();
    rd_chk(OFS_RESET_CAUSE, 32'h0000_001C);
    bus(1'b1, OFS_RESET_CAUSE, 32'h0000_0008, 4'hF);
    rd_chk(OFS_RESET_CAUSE, 32'h0000_0014);
    done("software");
    @(posedge clk);
    rst_n <= 1'b0;
    settle(1);
    chk1(tap_n, 1'b0);
    chk1(load_id, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_boot();
    rd_chk(OFS_RESET_CAUSE, CAUSE_POR_VALUE);
    rd_chk(OFS_BROWNOUT_CTRL, BROWNOUT_CTRL_RESET);
    done("second_power_on");
    tally_and_finish();
  end
endmodule : src_top_tb_top
